/* File: hw/core_irq_pkg.sv */
// constants for the core interrupt control block
package core_irq_pkg;
    localparam logic [7:0] CORE_IRQ_CTRL_OFS = 8'h0b;
    localparam logic [7:0] PIN_CHANGE_MASK_OFS = 8'h0c;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h0d;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h0e;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h0f;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int TIMER_ZERO_EN_BIT = 5;
    localparam int EXT_EN_BIT = 4;
    localparam int PORTB_EN_BIT = 3;
    localparam int TIMER_ZERO_FLAG_BIT = 2;
    localparam int EXT_FLAG_BIT = 1;
    localparam int PORTB_FLAG_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [3:0] IRQ_EV_RESET = 4'h0;
    localparam int NUM_EVENTS = 4;
endpackage

/* File: hw/pin_change_detect.sv */
// per-pin change detector for the eight port-B pins
module pin_change_detect
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] pins_i,
    input wire logic [7:0] mask_i,
    output logic change_o
);
    logic [7:0] last_q;
    logic [7:0] hit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            last_q <= 8'h00;
        end
        else
        begin
            last_q <= pins_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_pin
            assign hit[g] = mask_i[g] & (pins_i[g] ^ last_q[g]); // see R6
        end
    endgenerate

    assign change_o = |hit;
endmodule

/* File: hw/irq_event_status.sv */
// sticky event status with clear and enable masks
module irq_event_status
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] event_i,
    input wire logic [3:0] clear_i,
    input wire logic [3:0] enable_i,
    output logic [3:0] status_o,
    output logic irq_o
);
    import core_irq_pkg::*;
    logic [3:0] status_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status_q <= IRQ_EV_RESET;
        end
        else
        begin
            status_q <= (status_q & ~clear_i) | event_i;
        end
    end

    assign status_o = status_q;
    assign irq_o = |(status_q & enable_i);
endmodule

/* File: hw/core_interrupt_control.sv */
// core interrupt control register with flags, gates and register port
// Overview of operation
// R1: bit 7 is the global gate; no interrupt reaches the core while it is clear.
// R2: peripheral-group requests pass to the global gate only while bit 6 is set.
// R3: bit 5 enables the timer-0 overflow interrupt.
// R4: bit 4 enables the external edge-pin interrupt.
// R5: bit 3 enables the port-B change interrupt.
// R6: each port-B pin joins change detection only when its bit in the per-pin mask is set.
// R7: each flag is set by its event regardless of any enable bit.
// R8: software clears stale flags before setting enables.
// R9: flags 2, 1 and 0 stay set until software writes zero; bits 7 to 0 reset to zero.
//
// Strobed register access is this design's own decision.
module core_interrupt_control
(
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TIMER_ZERO_OVF_I,
    input wire logic EXTERNAL_EDGE_I,
    input wire logic [7:0] PORTB_PINS_I,
    input wire logic PERIPH_REQ_I,
    output logic CORE_IRQ_O,
    output logic BLOCK_IRQ_O
);
    import core_irq_pkg::*;

    logic [7:0] ctrl_q;
    logic [7:0] mask_q;
    logic [3:0] ev_en_q;
    logic [7:0] rdata_q;
    logic core_irq_q;
    logic block_irq_q;
    logic pin_change;
    logic [3:0] ev_status;
    logic block_irq;
    logic wr_ctrl;
    logic [3:0] ev_clear;
    logic [3:0] ev_set;
    logic [7:0] ctrl_d;

    pin_change_detect u_change
    (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .pins_i(PORTB_PINS_I),
        .mask_i(mask_q),
        .change_o(pin_change)
    );

    assign wr_ctrl = WR_I && (ADDR_I == CORE_IRQ_CTRL_OFS);

    // control register: software write, then hardware flag sets win
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d = WDATA_I; // see R9
        end
        if (TIMER_ZERO_OVF_I)
        begin
            ctrl_d[TIMER_ZERO_FLAG_BIT] = 1'b1; // see R7
        end
        if (EXTERNAL_EDGE_I)
        begin
            ctrl_d[EXT_FLAG_BIT] = 1'b1; // see R7
        end
        if (pin_change)
        begin
            ctrl_d[PORTB_FLAG_BIT] = 1'b1; // see R7
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            ctrl_q <= CTRL_RESET; // see R9
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            mask_q <= MASK_RESET;
        end
        else if (WR_I && (ADDR_I == PIN_CHANGE_MASK_OFS))
        begin
            mask_q <= WDATA_I; // see R6
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            ev_en_q <= IRQ_EV_RESET;
        end
        else if (WR_I && (ADDR_I == IRQ_ENABLE_OFS))
        begin
            ev_en_q <= WDATA_I[3:0];
        end
    end

    // block event status: bit3 core request, bits 2..0 the three sources
    assign ev_set = {core_irq_q, TIMER_ZERO_OVF_I, EXTERNAL_EDGE_I, pin_change};
    assign ev_clear = (WR_I && (ADDR_I == IRQ_CLEAR_OFS)) ? WDATA_I[3:0] : 4'h0;

    irq_event_status u_status
    (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .event_i(ev_set),
        .clear_i(ev_clear),
        .enable_i(ev_en_q),
        .status_o(ev_status),
        .irq_o(block_irq)
    );

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            core_irq_q <= 1'b0;
        end
        else
        begin
            core_irq_q <= ctrl_q[GLOBAL_EN_BIT] && ( // see R1
                (ctrl_q[TIMER_ZERO_EN_BIT] && ctrl_q[TIMER_ZERO_FLAG_BIT]) || // see R3
                (ctrl_q[EXT_EN_BIT] && ctrl_q[EXT_FLAG_BIT]) || // see R4
                (ctrl_q[PORTB_EN_BIT] && ctrl_q[PORTB_FLAG_BIT]) || // see R5
                (ctrl_q[PERIPH_EN_BIT] && PERIPH_REQ_I)); // see R2
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            block_irq_q <= 1'b0;
        end
        else
        begin
            block_irq_q <= block_irq;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            rdata_q <= 8'h00;
        end
        else if (RD_I)
        begin
            case (ADDR_I)
                CORE_IRQ_CTRL_OFS: rdata_q <= ctrl_q;
                PIN_CHANGE_MASK_OFS: rdata_q <= mask_q;
                IRQ_STATUS_OFS: rdata_q <= {4'h0, ev_status};
                IRQ_ENABLE_OFS: rdata_q <= {4'h0, ev_en_q};
                default: rdata_q <= 8'h00;
            endcase
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA_O = rdata_q;
    assign CORE_IRQ_O = core_irq_q;
    assign BLOCK_IRQ_O = block_irq_q;
endmodule

/* File: testbench/irq_ctrl_properties.sv */
// port assertions for the core interrupt control block
module irq_ctrl_properties
(
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic TIMER_ZERO_OVF_I,
    input wire logic EXTERNAL_EDGE_I,
    input wire logic PERIPH_REQ_I,
    input wire logic CORE_IRQ_O,
    input wire logic BLOCK_IRQ_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_ctl(b);
        WR_I && ADDR_I == 8'h0b && WDATA_I[7] && WDATA_I[b];
    endsequence
    property p_en(b, ev);
        s_ctl(b) ##1 ev && !WR_I |=> ##1 CORE_IRQ_O;
    endproperty
    property p_flag(ev, b);
        ev ##1 RD_I && ADDR_I == 8'h0b |=> RDATA_O[b];
    endproperty
    a_rd_refused: assert property (RD_I && (ADDR_I == 8'h0e || ADDR_I > 8'h0f) |=> RDATA_O == 8'h00)
        else $error("refused read not zero");
    a_gate_off: assert property (WR_I && ADDR_I == 8'h0b && !WDATA_I[7] ##1 !WR_I |=> !CORE_IRQ_O)
        else $error("irq with gate off");
    a_periph_pass: assert property (s_ctl(6) ##1 (PERIPH_REQ_I && !WR_I) [*2] |=> CORE_IRQ_O)
        else $error("peripheral irq missing");
    a_tmr_enable: assert property (p_en(5, TIMER_ZERO_OVF_I)) else $error("timer irq missing");
    a_ext_enable: assert property (p_en(4, EXTERNAL_EDGE_I)) else $error("edge irq missing");
    a_tmr_flag: assert property (p_flag(TIMER_ZERO_OVF_I, 2)) else $error("timer flag missing");
    a_ext_flag: assert property (p_flag(EXTERNAL_EDGE_I, 1)) else $error("edge flag missing");
    a_block_sticky: assert property (BLOCK_IRQ_O && !WR_I && !$past(WR_I) |=> BLOCK_IRQ_O)
        else $error("block irq dropped");
    c_core: cover property (CORE_IRQ_O);
    c_block: cover property (BLOCK_IRQ_O);
    c_refused: cover property (RD_I && ADDR_I == 8'h0e);
endmodule

bind core_interrupt_control irq_ctrl_properties i_irq_ctrl_properties (.*);

/* File: testbench/event_source.sv */
// event source model: timer overflow and external edge pulses
module event_source
(
    input wire logic [1:0] sel_i,
    output logic tmr_o,
    output logic ext_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign tmr_o = sel_i == 2'd1;
    assign ext_o = sel_i == 2'd2;
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the core interrupt control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, PERIPH_REQ_I = 0;
    logic [7:0] ADDR_I = 0, WDATA_I = 0, PORTB_PINS_I = 0, RDATA_O;
    logic TIMER_ZERO_OVF_I, EXTERNAL_EDGE_I, CORE_IRQ_O, BLOCK_IRQ_O;
    logic [1:0] sel = 0;
    int err_total = 0, checks = 0;
    core_interrupt_control i_core_interrupt_control (.*);
    event_source i_event_source (.sel_i(sel), .tmr_o(TIMER_ZERO_OVF_I), .ext_o(EXTERNAL_EDGE_I));
    always #50 SYS_CLK_I = ~SYS_CLK_I;
    task end_of_test;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        ADDR_I <= a; WDATA_I <= d; WR_I <= 1;
        @(posedge SYS_CLK_I);
        WR_I <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        ADDR_I <= a; RD_I <= 1;
        @(posedge SYS_CLK_I);
        RD_I <= 0;
        #1 chk(RDATA_O, e);
        @(posedge SYS_CLK_I);
    endtask
    task ev(input logic [1:0] s);
        sel <= s;
        @(posedge SYS_CLK_I);
        sel <= 0;
    endtask
    task settle;
        repeat (2) @(posedge SYS_CLK_I);
    endtask
    // outputs are looked at just after the edge, then the next edge is awaited so stimulus stays edge-aligned
    task chk_core(input logic e);
        #1 chk(CORE_IRQ_O, e);
        @(posedge SYS_CLK_I);
    endtask
    task chk_blk(input logic e);
        #1 chk(BLOCK_IRQ_O, e);
        @(posedge SYS_CLK_I);
    endtask
    task t_src(input logic [1:0] s, input int en, input int fl);
        wr(8'h0b, 8'h00); ev(s); rd(8'h0b, 8'h01 << fl);
        chk_core(0);
        wr(8'h0b, 8'h80 | 8'h01 << en); ev(s); settle; chk_core(1);
        wr(8'h0b, 8'h01 << en | 8'h01 << fl); settle; chk_core(0);
        rd(8'h0b, 8'h01 << en | 8'h01 << fl);
        wr(8'h0b, 8'h00); rd(8'h0b, 8'h00);
    endtask
    task t_pb;
        wr(8'h0c, 8'h01); PORTB_PINS_I <= 8'h02; settle; rd(8'h0b, 8'h00);
        PORTB_PINS_I <= 8'h03; settle; rd(8'h0b, 8'h01);
        wr(8'h0b, 8'h89); settle; chk_core(1);
        wr(8'h0b, 8'h00); rd(8'h0c, 8'h01);
    endtask
    task t_per;
        PERIPH_REQ_I <= 1; wr(8'h0b, 8'h80); settle; chk_core(0);
        wr(8'h0b, 8'hc0); settle; chk_core(1);
        PERIPH_REQ_I <= 0; wr(8'h0b, 8'h00); settle;
    endtask
    task t_blk;
        wr(8'h0e, 8'h0f); rd(8'h0d, 8'h00);
        wr(8'h0f, 8'h04); ev(1); settle; chk_blk(1);
        rd(8'h0d, 8'h04); rd(8'h0e, 8'h00); rd(8'h33, 8'h00);
        wr(8'h0f, 8'h00); settle; chk_blk(0);
        wr(8'h0f, 8'h04); settle; chk_blk(1);
        wr(8'h0e, 8'h04); settle; chk_blk(0); rd(8'h0d, 8'h00);
    endtask
    initial
    begin
        repeat (4) @(posedge SYS_CLK_I);
        RST_I <= 0;
        rd(8'h0b, 8'h00);
        t_src(2'd1, 5, 2);
        t_src(2'd2, 4, 1);
        t_pb;
        t_per;
        t_blk;
        end_of_test;
    end
    initial
    begin
        #200000;
        err_total++;
        end_of_test;
    end
endmodule
